// >>> hdl/pvp_pkg.sv
package pvp_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned SAMPLE_W = 16;
	localparam int unsigned FIFO_DEPTH = 8;
	localparam int unsigned NCO_W = 32;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_TXDATA = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_RXDATA = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'hC;

	// ****************************************
	// Control fields
	// ****************************************
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_MASTER_BIT = 1;
	localparam int unsigned CTRL_LONG_BIT = 2;
	localparam int unsigned CTRL_BCLK_LSB = 3;
	localparam int unsigned CTRL_FRAME_LSB = 5;
	localparam int unsigned CTRL_FS_BIT = 8;
	localparam int unsigned CTRL_REF_BIT = 9;
	localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_02B8;

	// ****************************************
	// Status fields
	// ****************************************
	localparam int unsigned ST_RX_VALID_BIT = 0;
	localparam int unsigned ST_UNDERRUN_BIT = 1;
	localparam int unsigned ST_OVERFLOW_BIT = 2;
	localparam int unsigned ST_TX_READY_BIT = 3;
	localparam int unsigned ST_TX_EMPTY_BIT = 4;
	localparam int unsigned ST_CFG_OK_BIT = 5;
	localparam int unsigned ST_RX_OVERRUN_BIT = 6;

	// ****************************************
	// Rates
	// ****************************************
	localparam longint CLK_HZ = 100_000_000;
	localparam longint BCLK_HZ_0 = 256_000;
	localparam longint BCLK_HZ_1 = 512_000;
	localparam longint BCLK_HZ_2 = 1_024_000;
	localparam longint BCLK_HZ_3 = 2_048_000;
	localparam longint FS_HZ_0 = 8_000;
	localparam longint FS_HZ_1 = 16_000;
	localparam longint REF_FS_HZ = 48_000;
	localparam longint REF_MULT = 256;
	localparam longint REF_HZ = REF_MULT * REF_FS_HZ;
	// Accumulator step giving two toggles per output period
	localparam logic [NCO_W-1:0] BCLK_INC_0 = NCO_W'((BCLK_HZ_0 << 33) / CLK_HZ);
	localparam logic [NCO_W-1:0] BCLK_INC_1 = NCO_W'((BCLK_HZ_1 << 33) / CLK_HZ);
	localparam logic [NCO_W-1:0] BCLK_INC_2 = NCO_W'((BCLK_HZ_2 << 33) / CLK_HZ);
	localparam logic [NCO_W-1:0] BCLK_INC_3 = NCO_W'((BCLK_HZ_3 << 33) / CLK_HZ);
	localparam logic [NCO_W-1:0] REF_INC = NCO_W'((REF_HZ << 33) / CLK_HZ);

	// ****************************************
	// Frame counting
	// ****************************************
	localparam logic [7:0] BIT_IDLE = 8'hFF;
	localparam logic [7:0] SAMPLE_LAST = 8'h0F;
	localparam logic [7:0] FRAME_MIN = 8'h08;
	localparam logic [2:0] FRAME_SEL_MAX = 3'h5;

	typedef enum logic {
		ROLE_SLAVE = 1'b0,
		ROLE_MASTER = 1'b1
	} pvp_role_t;

endpackage

// >>> hdl/pvp_fifo.sv
module pvp_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wr_ptr;
	logic [PW:0] rd_ptr;
	logic push;
	logic pop;

	// ****************************************
	// Flags
	// ****************************************
	assign in_ready = !((wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]));
	assign out_valid = (wr_ptr != rd_ptr);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr[PW-1:0]];

	// ****************************************
	// Storage
	// ****************************************
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr[PW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
		end else if (push) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end

endmodule

// >>> hdl/pvp_voice_port.sv
// Operation
// [R1] The port is master driving bit clock and frame sync, or slave taking both from the codec.
// [R2] Frame sync is a one-bit short pulse or a sixteen-bit long pulse, matching the codec.
// [R3] Every sample is a 16-bit linear word in both directions, without companding; with 8-period frames the code carries only the upper 8 bits.
// [R4] Bit clock is 256, 512, 1024 or 2048 kHz, with 2048 kHz after reset.
// [R5] Frame length is 8, 16, 32, 64, 128 or 256 bit clock periods.
// [R6] Sample rate, the frame sync repetition rate, is selectable between 8 kHz and 16 kHz; the code only compares it with the frame rate for cfg_ok.
// [R7] The reference clock output runs at 12.288 MHz by default for the codec.
// [R8] As an I2S master clock the reference clock is 256 times a 48 kHz sample rate.
// [R9] Bits go out MSB first from frame sync and are captured on the opposite bit clock edge.
// [R10] Bit periods after the 16 sample bits carry zeros on transmit data.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
module pvp_voice_port (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [pvp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pvp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pvp_pkg::DATA_W-1:0] reg_rdata,
	input wire logic pcm_clk_i,
	output logic pcm_clk_o,
	output logic pcm_clk_oe,
	input wire logic pcm_sync_i,
	output logic pcm_sync_o,
	output logic pcm_sync_oe,
	input wire logic pcm_din,
	output logic pcm_dout,
	output logic ref_clk,
	output logic tx_fifo_ready
);
	import pvp_pkg::*;

	logic [DATA_W-1:0] ctrl;
	logic enable;
	pvp_role_t role;
	logic long_sync;
	logic [1:0] bclk_sel;
	logic [2:0] frame_sel;
	logic fs_sel;
	logic ref_en;

	logic clk_s1, clk_s2, clk_s3;
	logic sync_s1, sync_s2, sync_s3;
	logic din_s1, din_s2;

	logic [NCO_W-1:0] bclk_inc;
	logic [NCO_W-1:0] bclk_acc;
	logic [NCO_W:0] next_bclk_acc;
	logic bclk_tick;
	logic [NCO_W-1:0] ref_acc;
	logic [NCO_W:0] next_ref_acc;

	logic rise;
	logic fall;
	logic frame_start;
	logic [2:0] frame_eff;
	logic [7:0] frame_last;
	logic [7:0] rx_last;
	logic [7:0] bit_cnt;

	logic [SAMPLE_W-1:0] tx_sh;
	logic [SAMPLE_W-1:0] tx_word;
	logic [SAMPLE_W-1:0] rx_sh;
	logic [SAMPLE_W-1:0] rx_cap;
	logic [SAMPLE_W-1:0] rx_data;
	logic rx_done;

	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [SAMPLE_W-1:0] fifo_out_data;

	logic rx_valid;
	logic rx_overrun;
	logic underrun;
	logic overflow;
	logic cfg_ok;
	logic [31:0] bclk_hz;
	logic [31:0] frame_hz;
	logic wr_ctrl, wr_tx, wr_status, rd_rx;

	// ****************************************
	// Register decode
	// ****************************************
	assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
	assign wr_tx = reg_wr && (reg_addr == ADDR_TXDATA);
	assign wr_status = reg_wr && (reg_addr == ADDR_STATUS);
	assign rd_rx = reg_rd && (reg_addr == ADDR_RXDATA);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= reg_wdata;
		end
	end

	assign enable = ctrl[CTRL_EN_BIT];
	assign role = pvp_role_t'(ctrl[CTRL_MASTER_BIT]);
	assign long_sync = ctrl[CTRL_LONG_BIT];
	assign bclk_sel = ctrl[CTRL_BCLK_LSB +: 2];
	assign frame_sel = ctrl[CTRL_FRAME_LSB +: 3];
	assign fs_sel = ctrl[CTRL_FS_BIT];
	assign ref_en = ctrl[CTRL_REF_BIT];

	// ****************************************
	// Pin synchronisers
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clk_s1 <= 1'b0;
			clk_s2 <= 1'b0;
			clk_s3 <= 1'b0;
			sync_s1 <= 1'b0;
			sync_s2 <= 1'b0;
			sync_s3 <= 1'b0;
			din_s1 <= 1'b0;
			din_s2 <= 1'b0;
		end else begin
			clk_s1 <= pcm_clk_i;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
			sync_s1 <= pcm_sync_i;
			sync_s2 <= sync_s1;
			sync_s3 <= sync_s2;
			din_s1 <= pcm_din;
			din_s2 <= din_s1;
		end
	end

	// ****************************************
	// Bit clock generator
	// ****************************************
	always_comb begin
		unique case (bclk_sel) // see [R4]
			2'd0: bclk_inc = BCLK_INC_0;
			2'd1: bclk_inc = BCLK_INC_1;
			2'd2: bclk_inc = BCLK_INC_2;
			2'd3: bclk_inc = BCLK_INC_3;
		endcase
	end

	assign next_bclk_acc = {1'b0, bclk_acc} + {1'b0, bclk_inc};
	assign bclk_tick = next_bclk_acc[NCO_W];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bclk_acc <= '0;
		end else if (enable && role == ROLE_MASTER) begin
			bclk_acc <= next_bclk_acc[NCO_W-1:0];
		end else begin
			bclk_acc <= '0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pcm_clk_o <= 1'b0;
		end else if (!(enable && role == ROLE_MASTER)) begin
			pcm_clk_o <= 1'b0;
		end else if (bclk_tick) begin
			pcm_clk_o <= !pcm_clk_o; // see [R1]
		end
	end

	assign pcm_clk_oe = enable && (role == ROLE_MASTER); // see [R1]
	assign pcm_sync_oe = enable && (role == ROLE_MASTER); // see [R1]

	// ****************************************
	// Reference clock
	// ****************************************
	assign next_ref_acc = {1'b0, ref_acc} + {1'b0, REF_INC}; // see [R8]

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ref_acc <= '0;
			ref_clk <= 1'b0;
		end else if (!ref_en) begin
			ref_acc <= '0;
			ref_clk <= 1'b0;
		end else begin
			ref_acc <= next_ref_acc[NCO_W-1:0];
			if (next_ref_acc[NCO_W]) begin
				ref_clk <= !ref_clk; // see [R7]
			end
		end
	end

	// ****************************************
	// Bit clock edges and frame timing
	// ****************************************
	always_comb begin
		if (role == ROLE_MASTER) begin
			rise = enable && bclk_tick && !pcm_clk_o;
			fall = enable && bclk_tick && pcm_clk_o;
			frame_start = rise && (bit_cnt >= frame_last);
		end else begin
			rise = enable && clk_s2 && !clk_s3;
			fall = enable && !clk_s2 && clk_s3;
			frame_start = enable && sync_s2 && !sync_s3; // see [R1]
		end
	end

	assign frame_eff = (frame_sel > FRAME_SEL_MAX) ? FRAME_SEL_MAX : frame_sel;
	assign frame_last = 8'((9'(FRAME_MIN) << frame_eff) - 9'd1); // see [R5]
	assign rx_last = (frame_last < SAMPLE_LAST) ? frame_last : SAMPLE_LAST;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= BIT_IDLE;
		end else if (!enable) begin
			bit_cnt <= BIT_IDLE;
		end else if (frame_start) begin
			bit_cnt <= '0; // see [R5]
		end else if (rise && bit_cnt != BIT_IDLE) begin
			bit_cnt <= bit_cnt + 8'd1;
		end
	end

	// ****************************************
	// Frame sync output
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pcm_sync_o <= 1'b0;
		end else if (!(enable && role == ROLE_MASTER)) begin
			pcm_sync_o <= 1'b0;
		end else if (frame_start) begin
			pcm_sync_o <= 1'b1; // see [R2]
		end else if (rise) begin
			pcm_sync_o <= long_sync && ((bit_cnt + 8'd1) <= SAMPLE_LAST); // see [R2]
		end
	end

	// ****************************************
	// Transmit path
	// ****************************************
	assign tx_word = fifo_out_valid ? fifo_out_data : '0;
	assign fifo_in_valid = wr_tx;
	assign tx_fifo_ready = fifo_in_ready;

	pvp_fifo #(
		.WIDTH(SAMPLE_W),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(reg_wdata[SAMPLE_W-1:0]),
		.out_valid(fifo_out_valid),
		.out_ready(frame_start),
		.out_data(fifo_out_data)
	);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tx_sh <= '0;
			pcm_dout <= 1'b0;
		end else if (!enable) begin
			tx_sh <= '0;
			pcm_dout <= 1'b0;
		end else if (frame_start) begin
			tx_sh <= tx_word; // see [R3]
			pcm_dout <= tx_word[SAMPLE_W-1]; // see [R9]
		end else if (rise && bit_cnt != BIT_IDLE) begin
			tx_sh <= {tx_sh[SAMPLE_W-2:0], 1'b0}; // see [R10]
			pcm_dout <= tx_sh[SAMPLE_W-2]; // see [R9]
		end
	end

	// ****************************************
	// Receive path
	// ****************************************
	assign rx_cap = {rx_sh[SAMPLE_W-2:0], din_s2};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_sh <= '0;
			rx_data <= '0;
			rx_done <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			if (fall && bit_cnt <= rx_last) begin
				rx_sh <= rx_cap; // see [R9]
				if (bit_cnt == rx_last) begin
					rx_done <= 1'b1;
					if (rx_last < SAMPLE_LAST) begin
						rx_data <= {rx_cap[7:0], 8'h00};
					end else begin
						rx_data <= rx_cap; // see [R3]
					end
				end
			end
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_valid <= 1'b0;
		end else if (rx_done) begin
			rx_valid <= 1'b1;
		end else if (rd_rx) begin
			rx_valid <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rx_overrun <= 1'b0;
		end else if (rx_done && rx_valid && !rd_rx) begin
			rx_overrun <= 1'b1;
		end else if (wr_status && reg_wdata[ST_RX_OVERRUN_BIT]) begin
			rx_overrun <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			underrun <= 1'b0;
		end else if (frame_start && !fifo_out_valid) begin
			underrun <= 1'b1;
		end else if (wr_status && reg_wdata[ST_UNDERRUN_BIT]) begin
			underrun <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			overflow <= 1'b0;
		end else if (wr_tx && !fifo_in_ready) begin
			overflow <= 1'b1;
		end else if (wr_status && reg_wdata[ST_OVERFLOW_BIT]) begin
			overflow <= 1'b0;
		end
	end

	always_comb begin
		unique case (bclk_sel)
			2'd0: bclk_hz = 32'(BCLK_HZ_0);
			2'd1: bclk_hz = 32'(BCLK_HZ_1);
			2'd2: bclk_hz = 32'(BCLK_HZ_2);
			2'd3: bclk_hz = 32'(BCLK_HZ_3);
		endcase
	end

	assign frame_hz = (fs_sel ? 32'(FS_HZ_1) : 32'(FS_HZ_0)) << (4'(frame_eff) + 4'd3);
	assign cfg_ok = (bclk_hz == frame_hz); // see [R6]

	// ****************************************
	// Read data
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_CTRL: reg_rdata <= ctrl;
				ADDR_RXDATA: reg_rdata <= {16'h0000, rx_data};
				ADDR_STATUS: reg_rdata <= {25'h000_0000, rx_overrun, cfg_ok,
					!fifo_out_valid, fifo_in_ready, overflow, underrun, rx_valid};
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

endmodule

// >>> tb/pvp_voice_port_sva.sv
module pvp_voice_port_chk (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic pcm_clk_o,
	input wire logic pcm_clk_oe,
	input wire logic pcm_sync_o,
	input wire logic pcm_sync_oe,
	input wire logic pcm_dout,
	input wire logic ref_clk
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_oe_pair: assert property (pcm_clk_oe == pcm_sync_oe)
		else $error("bit clock and sync enables differ");
	a_sync_on_rise: assert property ($rose(pcm_sync_o) |-> $rose(pcm_clk_o))
		else $error("sync rose off a bit clock rise");
	a_dout_on_rise: assert property (pcm_clk_oe && $changed(pcm_dout) |-> $rose(pcm_clk_o))
		else $error("transmit data changed off a bit clock rise");
	a_bclk_high_min: assert property ($rose(pcm_clk_o) |-> (pcm_clk_o || !pcm_clk_oe)[*8])
		else $error("bit clock high too short");
	a_bclk_low_min: assert property ($fell(pcm_clk_o) |-> (!pcm_clk_o || !pcm_clk_oe)[*8])
		else $error("bit clock low too short");
	a_bclk_half_max: assert property ($rose(pcm_clk_o) |-> ##[1:200] (!pcm_clk_o || !pcm_clk_oe))
		else $error("bit clock high too long");
	a_ref_half: assert property ($rose(ref_clk) |-> ##[3:5] $fell(ref_clk))
		else $error("reference clock high time off");
	a_ref_low_min: assert property ($fell(ref_clk) |-> !ref_clk[*4])
		else $error("reference clock low too short");
endmodule

bind pvp_voice_port pvp_voice_port_chk u_pvp_voice_port_chk (
	.clock(clock),
	.rst_n(rst_n),
	.pcm_clk_o(pcm_clk_o),
	.pcm_clk_oe(pcm_clk_oe),
	.pcm_sync_o(pcm_sync_o),
	.pcm_sync_oe(pcm_sync_oe),
	.pcm_dout(pcm_dout),
	.ref_clk(ref_clk)
);

// >>> tb/pvp_codec_model.sv
module pvp_codec_model (
	input wire logic bclk,
	input wire logic sync,
	input wire logic dout,
	input wire logic gen,
	input wire logic [15:0] tx_word,
	output logic clk_g,
	output logic sync_g,
	output logic din,
	output logic [31:0] rx_word,
	output int frames
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] sh = '0;
	logic prev = 0;
	int idx = 32;
	initial begin
		clk_g = 0;
		sync_g = 0;
		din = 0;
		rx_word = '0;
		frames = 0;
	end
	// Slave frames: codec makes clock and short sync, still between frames
	initial forever begin
		wait (gen);
		for (int i = 0; i < 32; i++) begin
			sync_g <= (i == 0);
			clk_g <= 1;
			#80;
			clk_g <= 0;
			#80;
		end
		sync_g <= 0;
		#320;
	end
	// Capture on falling edge, MSB first from sync
	always @(negedge bclk) begin
		if (sync && !prev)
			idx = 0;
		prev = sync;
		if (idx < 32) begin
			sh = {sh[30:0], dout};
			idx++;
			if (idx == 32) begin
				rx_word <= sh;
				frames <= frames + 1;
			end
		end
	end
	always @(posedge bclk) begin
		din <= tx_word[(idx < 16) ? 15 - idx : 15];
	end
endmodule

// >>> tb/test_pvp_voice_port.sv
module test_pvp_voice_port;
	timeunit 1ns;
	timeprecision 1ns;
	import pvp_pkg::*;
	logic clock = 0;
	logic rst_n = 0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic [DATA_W-1:0] reg_rdata, rd_v;
	logic pcm_clk_o, pcm_clk_oe, pcm_sync_o, pcm_sync_oe, pcm_din, pcm_dout, ref_clk;
	logic tx_fifo_ready, clk_g, sync_g, rp;
	logic gen = 0;
	logic [15:0] tx_word = 16'h3C96;
	logic [31:0] rx_word;
	int frames, n, h, f0;
	int error_cnt = 0;
	int check_count = 0;
	longint bhz[4] = '{BCLK_HZ_0, BCLK_HZ_1, BCLK_HZ_2, BCLK_HZ_3};
	logic [DATA_W-1:0] cfg[3] = '{32'h0000_02B8, 32'h0000_03B8, 32'h0000_0398};
	wire logic pcm_clk = pcm_clk_oe ? pcm_clk_o : clk_g;
	wire logic pcm_sync = pcm_sync_oe ? pcm_sync_o : sync_g;
	always #5 clock = ~clock;

	pvp_voice_port u_pvp_voice_port (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pcm_clk_i(pcm_clk), .pcm_clk_o(pcm_clk_o), .pcm_clk_oe(pcm_clk_oe),
		.pcm_sync_i(pcm_sync), .pcm_sync_o(pcm_sync_o), .pcm_sync_oe(pcm_sync_oe),
		.pcm_din(pcm_din), .pcm_dout(pcm_dout), .ref_clk(ref_clk),
		.tx_fifo_ready(tx_fifo_ready));
	pvp_codec_model u_pvp_codec_model (.bclk(pcm_clk), .sync(pcm_sync), .dout(pcm_dout),
		.gen(gen), .tx_word(tx_word), .clk_g(clk_g), .sync_g(sync_g), .din(pcm_din),
		.rx_word(rx_word), .frames(frames));

	function automatic logic [15:0] smp(input int k);
		return 16'(16'h1E0F * (k + 1));
	endfunction
	task end_sim;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk_near(input string nm, input longint e, input int g);
		check_count++;
		if (g < e - 2 || g > e + 2) begin
			error_cnt++;
			$display("wrong value %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clock);
		reg_wr <= 0;
	endtask
	task rd(input logic [ADDR_W-1:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clock);
		reg_rd <= 0;
		#1 rd_v = reg_rdata;
	endtask
	task wait_sync;
		logic p;
		n = 0;
		h = 0;
		p = pcm_sync;
		forever begin
			@(posedge clock);
			#1;
			n++;
			if (pcm_sync === 1'b1)
				h++;
			if (pcm_sync === 1'b1 && p !== 1'b1)
				break;
			p = pcm_sync;
			if (n > 30000) begin
				error_cnt++;
				end_sim;
			end
		end
	endtask
	task wait_frame;
		f0 = frames;
		for (int i = 0; frames == f0; i++) begin
			@(posedge clock);
			if (i > 20000) begin
				error_cnt++;
				end_sim;
			end
		end
	endtask
	task measure(input int b, input int f, input int lng);
		wr(ADDR_CTRL, DATA_W'(32'h0000_0203 + (b << 3) + (f << 5) + (lng << 2)));
		wait_sync;
		wait_sync;
		chk_near("frame cycles", (8 << f) * CLK_HZ / bhz[b], n);
		chk_near("sync high", (lng ? 16 : 1) * CLK_HZ / bhz[b] + 1, h);
	endtask

	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1;
		rd(ADDR_CTRL);
		chk("ctrl reset", CTRL_RESET, rd_v);
		rd(4'h2);
		chk("unmapped read", 32'h0000_0000, rd_v);
		n = 0;
		rp = ref_clk;
		repeat (10000) begin
			@(posedge clock);
			#1;
			if (ref_clk && !rp)
				n++;
			rp = ref_clk;
		end
		chk_near("ref rises", REF_HZ / 10_000, n);
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_CTRL, cfg[i]);
			rd(ADDR_STATUS);
			chk("cfg ok", {31'h0, i != 1}, {31'h0, rd_v[ST_CFG_OK_BIT]});
		end
		for (int b = 0; b < 4; b++)
			measure(b, 1, 0);
		for (int f = 0; f < 6; f++)
			measure(3, f, f > 2);
		wr(ADDR_CTRL, 32'h0000_0200);
		wr(ADDR_TXDATA, 32'h0000_A5C3);
		wr(ADDR_CTRL, 32'h0000_025B);
		wait_frame;
		chk("master frame", 32'hA5C3_0000, rx_word);
		rd(ADDR_RXDATA);
		chk("rx sample", {16'h0, tx_word}, rd_v);
		wr(ADDR_CTRL, 32'h0000_0200);
		for (int k = 0; k < 9; k++)
			wr(ADDR_TXDATA, {16'h0, smp(k)});
		chk("fifo ready", 32'h0, {31'h0, tx_fifo_ready});
		rd(ADDR_STATUS);
		chk("overflow", 32'h1, {31'h0, rd_v[ST_OVERFLOW_BIT]});
		wr(ADDR_CTRL, 32'h0000_0259);
		gen <= 1;
		for (int k = 0; k < 8; k++) begin
			wait_frame;
			chk("slave frame", {smp(k), 16'h0}, rx_word);
		end
		gen <= 0;
		chk("clock drive", 32'h0, {31'h0, pcm_clk_oe});
		rd(ADDR_STATUS);
		chk("fifo empty", 32'h1, {31'h0, rd_v[ST_TX_EMPTY_BIT]});
		for (n = 0; n < 20; n++) begin
			rp = ref_clk;
			@(posedge clock);
			#1;
			if (rp && !ref_clk)
				break;
		end
		wr(ADDR_CTRL, 32'h0000_0000);
		n = 0;
		repeat (40) begin
			@(posedge clock);
			#1;
			n += ref_clk;
		end
		chk("ref stopped", 32'h0, n);
		end_sim;
	end
endmodule
